// >>> rtl/ebpsm_port.sv
// port one: latch, direction and segment select with pin multiplexer
// assumes cpu read strobe marks the sample state, write strobe the
// update state; pins arrive asynchronously and pass three flops
module ebpsm_port
  import ebpsm_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic              bus_rd,
  input  wire logic              bus_wr,
  input  wire logic [WIDTH-1:0]  bus_wdata,
  output logic      [WIDTH-1:0]  bus_rdata,
  input  wire logic [WIDTH-1:0]  port_one_in,
  output logic      [WIDTH-1:0]  port_one_out,
  output logic      [WIDTH-1:0]  port_one_oe,
  input  wire logic [WIDTH-1:0]  segment_line_in,
  input  wire logic              serial_tx_in,
  output logic                   serial_rx_out,
  output logic      [2:0]        external_interrupt_out
);
  logic             rst_a_q, rst_b_q, rst_n;
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
  logic [WIDTH-1:0] latch_q, latch_d, dir_q, dir_d, seg_q, seg_d;
  logic [WIDTH-1:0] rdata_q, rdata_d, rd_view;
  logic             sel_latch, sel_dir, sel_seg;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_b_q <= rst_a_q;
    end
  end
  assign rst_n = rst_b_q;

  assign sel_latch = (bus_addr == OFS_LATCH);
  assign sel_dir   = (bus_addr == OFS_DIRECTION);
  assign sel_seg   = (bus_addr == OFS_SEGMENT);

  // pin level accepted only once second and third flops agree
  always_comb begin
    pin_d = pin_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        pin_d[i] = s3_q[i];
      end
    end
  end

  // no input latch: view is live every cycle, caught only on reads
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (dir_q[i]) begin
        rd_view[i] = latch_q[i];
      end else if (seg_q[i]) begin
        rd_view[i] = 1'b0;
      end else begin
        rd_view[i] = pin_q[i];
      end
    end
  end

  always_comb begin
    latch_d = latch_q;
    dir_d   = dir_q;
    seg_d   = seg_q;
    rdata_d = rdata_q;
    if (bus_wr && sel_latch) begin
      latch_d = bus_wdata[WIDTH-1:0];
    end
    if (bus_wr && sel_dir) begin
      dir_d = bus_wdata[WIDTH-1:0];
    end
    if (bus_wr && sel_seg) begin
      seg_d = bus_wdata[WIDTH-1:0];
    end
    if (bus_rd) begin
      // sampled in the read cycle; unmapped reads give zero
      if (sel_latch) begin
        rdata_d = rd_view;
      end else if (sel_dir) begin
        rdata_d = dir_q;
      end else if (sel_seg) begin
        rdata_d = seg_q;
      end else begin
        rdata_d = '0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      pin_q   <= '0;
      latch_q <= RST_LATCH;
      dir_q   <= RST_DIRECTION;
      seg_q   <= RST_SEGMENT;
      rdata_q <= '0;
    end else begin
      s1_q    <= port_one_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      pin_q   <= pin_d;
      latch_q <= latch_d;
      dir_q   <= dir_d;
      seg_q   <= seg_d;
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;

  // pin driver: segment wins over everything, else direction decides
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (seg_q[i]) begin
        port_one_out[i] = segment_line_in[i];
        port_one_oe[i]  = 1'b1;
      end else begin
        port_one_out[i] = latch_q[i];
        port_one_oe[i]  = dir_q[i];
      end
    end
    // transmit is anded with the latch so latch 1 lets it through
    if (!seg_q[BIT_SER_TX]) begin
      port_one_out[BIT_SER_TX] = latch_q[BIT_SER_TX] & serial_tx_in;
    end
  end

  // secondary inputs see the filtered pin; gated off in segment mode
  assign serial_rx_out = pin_q[BIT_SER_RX] & ~seg_q[BIT_SER_RX];
  assign external_interrupt_out =
    pin_q[BIT_INT_THREE:BIT_INT_ONE] & ~seg_q[BIT_INT_THREE:BIT_INT_ONE];

  a_reset_clears: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> (latch_q == '0 && dir_q == '0 && seg_q == '0))
    else $error("registers not clear after reset");

  a_write_updates: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (bus_wr && sel_latch) |=> latch_q == $past(bus_wdata))
    else $error("latch write not applied");

  a_dir_write: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (bus_wr && sel_dir) |=> dir_q == $past(bus_wdata))
    else $error("direction write not applied");

  a_seg_write: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (bus_wr && sel_seg) |=> seg_q == $past(bus_wdata))
    else $error("segment select write not applied");

  // read result must stand until the next read strobe
  a_read_hold: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !bus_rd |=> $stable(bus_rdata))
    else $error("read data changed without a read");

  a_unmapped_zero: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (bus_rd && !sel_latch && !sel_dir && !sel_seg) |=> bus_rdata == '0)
    else $error("unmapped read not zero");

  a_rx_route: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !seg_q[BIT_SER_RX] |-> serial_rx_out == pin_q[BIT_SER_RX])
    else $error("receive not routed from bit 0");

  a_int_route: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !seg_q[BIT_INT_ONE] |-> external_interrupt_out[0] == pin_q[BIT_INT_ONE])
    else $error("interrupt one not routed from bit 2");

  a_tx_route: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !seg_q[BIT_SER_TX] |->
      port_one_out[BIT_SER_TX] == (latch_q[BIT_SER_TX] & serial_tx_in))
    else $error("transmit not routed to bit 1");

  // per-bit checks: random mode mixes reach every branch on some bit,
  // whereas whole-byte antecedents would almost never fire
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit_chk
    a_seg_drives: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      seg_q[g] |->
        (port_one_oe[g] && port_one_out[g] == segment_line_in[g]))
      else $error("segment select not driving segment");

    a_oe_follows: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      !seg_q[g] |-> port_one_oe[g] == dir_q[g])
      else $error("enable does not follow direction");

    a_read_out_mode: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      (bus_rd && sel_latch && dir_q[g]) |=>
        bus_rdata[g] == $past(latch_q[g]))
      else $error("output mode read not latch");

    a_read_seg_zero: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      (bus_rd && sel_latch && !dir_q[g] && seg_q[g]) |=> !bus_rdata[g])
      else $error("segment mode read not zero");

    a_read_input: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      (bus_rd && sel_latch && !dir_q[g] && !seg_q[g]) |=>
        bus_rdata[g] == $past(pin_q[g]))
      else $error("input mode read not pin level");
  end

  c_out_write: cover property (@(posedge clk_sys) bus_wr && sel_latch);
  c_in_read: cover property (@(posedge clk_sys)
    bus_rd && sel_latch && dir_q == '0);
  c_seg_mode: cover property (@(posedge clk_sys) seg_q != '0);
  c_mixed_read: cover property (@(posedge clk_sys)
    bus_rd && sel_latch && dir_q != '0 && seg_q != '0
    && (~dir_q & ~seg_q) != '0);
endmodule : ebpsm_port

// >>> include/ebpsm_pkg.sv
// constants for the eight-bit port with segment multiplexer
// assumes a byte-wide cpu bus with separate read and write strobes
package ebpsm_pkg;
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFS_LATCH     = 12'h0001;
  localparam logic [11:0] OFS_DIRECTION = 12'h0009;
  localparam logic [11:0] OFS_SEGMENT   = 12'h0f9e;
  localparam logic [7:0]  RST_LATCH     = 8'h00;
  localparam logic [7:0]  RST_DIRECTION = 8'h00;
  localparam logic [7:0]  RST_SEGMENT   = 8'h00;
  localparam int          BIT_SER_RX    = 0;
  localparam int          BIT_SER_TX    = 1;
  localparam int          BIT_INT_ONE   = 2;
  localparam int          BIT_INT_THREE = 4;
endpackage : ebpsm_pkg

// >>> sim/ebpsm_pin_model.sv
// board around port one: each pin is either driven by the port
// or by an outside source whose level the bench chooses
module ebpsm_pin_model (
  input  wire logic [7:0] drive_en,
  input  wire logic [7:0] drive_lvl,
  input  wire logic [7:0] ext_lvl,
  output logic      [7:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 100ps;
  // per-pin resolution, no shared level between pins
  assign pin_lvl = (drive_en & drive_lvl) | (~drive_en & ext_lvl);
endmodule : ebpsm_pin_model

// >>> sim/test_eight_bit_port_with_segment_mux.sv
// bench for port one: random mode mixes, drive, readback and routing
// assumes ebpsm_pin_model closes the pins; reads checked from a queue
module test_eight_bit_port_with_segment_mux;
  import ebpsm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_sys = 1'b0, nrst = 1'b0, bus_rd = 1'b0, bus_wr = 1'b0;
  logic       tx = 1'b1, rd_d = 1'b0, rx;
  logic [2:0] eint;
  logic [11:0] bus_addr = 12'h000;
  logic [7:0] wd = 8'h00, segl = 8'h00, ext = 8'h00, rdat, pout, poe, pin;
  logic [7:0] dir, seg, lat, oexp, oe, pe;
  logic [7:0] exp_q[$];
  int         fails = 0, checked = 0, seed = 32'hc18d_b927;
  always #2.5 clk_sys = ~clk_sys;
  ebpsm_port dut_u (.clk_sys(clk_sys), .nrst(nrst), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(wd), .bus_rdata(rdat),
    .port_one_in(pin), .port_one_out(pout), .port_one_oe(poe),
    .segment_line_in(segl), .serial_tx_in(tx), .serial_rx_out(rx),
    .external_interrupt_out(eint));
  ebpsm_pin_model pin_u (.drive_en(poe), .drive_lvl(pout), .ext_lvl(ext),
    .pin_lvl(pin));
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge clk_sys) #1;
    bus_addr = a;
    wd = d;
    bus_wr = 1'b1;
    @(posedge clk_sys) #1 bus_wr = 1'b0;
  endtask : wr
  task automatic rd(logic [11:0] a, logic [7:0] e);
    @(posedge clk_sys) #1;
    bus_addr = a;
    bus_rd = 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys) #1 bus_rd = 0;
  endtask : rd
  // read data lands with the taking edge; look once it has settled
  always @(posedge clk_sys) begin
    rd_d = bus_rd;
    #2;
    if (rd_d) chk("read data", exp_q.pop_front(), rdat);
  end
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (12) @(posedge clk_sys);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("enable", 8'h00, poe);
    rd(OFS_DIRECTION, RST_DIRECTION);
    rd(OFS_SEGMENT, RST_SEGMENT);
    rd(OFS_LATCH, 8'h00);
    rd(12'h0f9f, 8'h00);
    // loop below uses only the three mapped offsets
    for (int i = 0; i < 40; i++) begin
      dir = 8'($random(seed));
      seg = 8'($random(seed));
      lat = 8'($random(seed));
      segl = 8'($random(seed));
      ext = 8'($random(seed));
      tx = 1'($random(seed));
      // whole-byte writes, never read-modify-write
      wr(OFS_DIRECTION, dir);
      wr(OFS_SEGMENT, seg);
      wr(OFS_LATCH, lat);
      // transmit level only reaches the pin through a set latch bit
      oexp = (seg & segl) | (~seg & lat & {6'h3f, tx, 1'h1});
      oe = dir | seg;
      chk("enable", oe, poe);
      chk("drive", oexp & oe, pout & poe);
      repeat (8) @(posedge clk_sys);
      pe = (oe & oexp) | (~oe & ext);
      chk("routing", {4'h0, ~seg[4:2] & pe[4:2], ~seg[0] & pe[0]},
        {4'h0, eint, rx});
      rd(OFS_LATCH, (dir & lat) | (~dir & ~seg & ext));
      rd(OFS_DIRECTION, dir);
      rd(OFS_SEGMENT, seg);
    end
    repeat (3) @(posedge clk_sys);
    give_verdict();
  end
  initial begin
    #(3000 * 5);
    fails++;
    give_verdict();
  end
endmodule : test_eight_bit_port_with_segment_mux
